// *** usrw_change_det.sv ***
/*
 * usrw_change_det: three-stage pin synchroniser with change detection.
 * Assumes an asynchronous pin; emits a one-cycle pulse per settled level change.
 */
`timescale 1ns/1ns
module usrw_change_det
(
    input  wire logic clock,
    input  wire logic rst,
    input  wire logic pin,
    output logic      change_pulse
);
    logic [2:0] sync;
    logic       stable;
    logic       primed;
    logic [2:0] next_sync;
    logic       next_stable;
    logic       next_primed;
    logic       next_change_pulse;
    logic [1:0] fill;
    logic [1:0] next_fill;

    always_comb
    begin
        next_sync         = {sync[1:0], pin};
        next_fill         = (fill == 2'h3) ? fill : fill + 2'h1;
        next_stable       = stable;
        next_primed       = primed;
        next_change_pulse = 1'b0;
        // only stages two and three are compared; stage one feeds stage two alone
        // stages reset to zero: no compare until the pin has filled all three,
        // else a pin high at reset would look like a change
        if (fill == 2'h3 && sync[1] == sync[2])
        begin
            next_stable = sync[2];
            next_primed = 1'b1;
            // first settled level after reset is taken as the baseline, not a change
            next_change_pulse = primed && (sync[2] != stable);
        end
    end

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            sync         <= 3'h0;
            fill         <= 2'h0;
            stable       <= 1'b0;
            primed       <= 1'b0;
            change_pulse <= 1'b0;
        end
        else
        begin
            sync         <= next_sync;
            fill         <= next_fill;
            stable       <= next_stable;
            primed       <= next_primed;
            change_pulse <= next_change_pulse;
        end
    end
endmodule

// *** usrw_host_model.sv ***
/*
 * usrw_host_model: upstream host seen from the wake logic.
 * Assumes the bench asks for suspend and host resume on plain levels.
 */
`timescale 1ns/1ns
module usrw_host_model
(
    input  wire logic clock,
    input  wire logic rst,
    input  wire logic go_suspend,
    input  wire logic wake_host,
    input  wire logic resume_start,
    output logic      suspended,
    output logic      host_resume,
    output int        resume_count
);
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            suspended    <= 1'b0;
            host_resume  <= 1'b0;
            resume_count <= 0;
        end
        else
        begin
            // host resume ends the suspend at once
            suspended   <= go_suspend & ~wake_host;
            host_resume <= wake_host;
            if (resume_start)
                resume_count <= resume_count + 1;
        end
    end
endmodule

// *** usrw_pkg.sv ***
/*
 * usrw_pkg: shared constants and types of the suspend wake-event logic.
 * Assumes a single 20 MHz core clock and firmware register images on plain ports.
 */
package usrw_pkg;

    // clock and resume timing
    localparam int CLK_HZ             = 20_000_000;
    localparam int RESUME_TIMEOUT_MS  = 10;
    // at least one cycle; rounds down
    localparam int RESUME_TIMEOUT_CYC = (RESUME_TIMEOUT_MS * (CLK_HZ / 1000) < 1) ? 1 :
                                        RESUME_TIMEOUT_MS * (CLK_HZ / 1000);

    // usb_control_reg fields
    localparam int CTL_LOW_POWER_BIT  = 6;
    localparam int CTL_REMOTE_WK_BIT  = 5;
    // usb_irq_mask_reg fields
    localparam int MSK_WAKE_IRQ_BIT   = 2;
    // mcu_config_reg fields
    localparam int CFG_PORT34_BIT     = 2;
    localparam int CFG_PORT35_BIT     = 3;
    localparam int CFG_CARD1_BIT      = 4;
    localparam int CFG_CARD2_BIT      = 5;

    localparam int NUM_SOURCES        = 5;

    // reset values
    localparam logic [4:0] SRC_RESET  = 5'h00;
    localparam logic       IRQ_RESET  = 1'b0;

    // wake_source_reg layout, one bit per change source
    typedef struct packed {
        logic card2;    // port 3.3
        logic card1;    // port 3.2
        logic port35;
        logic port34;
        logic vbus;
    } usrw_src_t;

    typedef enum {
        USRW_RUN,
        USRW_STOP,
        USRW_WAKE,
        USRW_ARMED,
        USRW_DONE
    } usrw_state_t;

endpackage

// *** usrw_wake_ctrl.sv ***
/*
 * usrw_wake_ctrl: suspend-time wake events, wake interrupt, clock restart and
 * upstream resume request. Assumes suspend entry and host resume come from the
 * link logic on the same clock, and that this logic sits on the always-on clock
 * while core_clock_enable gates the rest of the core.
 */
`timescale 1ns/1ns
// Summary of operation
// - suspended, remote wake armed, enabled pin change: restart clock, irq, resume
// - resume starts on irq clear or 10 ms after irq, whichever first
// - vbus change detection always on; only four gpio sources have enables
// - no remote wake, no low power: clock runs, events raise irq at once
// - low power set: clock stops in suspend; without remote wake armed, events latched without irq
// - stopped clock waits for host resume; latched event then raises irq
// - low power enable is control register bit 6, decides clock stop
// - irq enable is mask bit 2; gates irq and, with remote wake, restart
// - remote wake enable is control bit 5; decides resume and clock restart
// - config bits 2..5 enable change detect on ports 3.4, 3.5, 3.2, 3.3
// - source pulses ored set status only when enabled and not already set
// - writing one clears status; source bits held until cleared one by one
module usrw_wake_ctrl
#(
    parameter int RESUME_CYCLES = usrw_pkg::RESUME_TIMEOUT_CYC
)
(
    input  wire logic            clock,
    input  wire logic            rst,
    input  wire logic [7:0]      usb_control_reg,
    input  wire logic [7:0]      usb_irq_mask_reg,
    input  wire logic [7:0]      mcu_config_reg,
    input  wire logic            vbus_pin,
    input  wire logic            port34_pin,
    input  wire logic            port35_pin,
    input  wire logic            port32_pin,
    input  wire logic            port33_pin,
    input  wire logic            suspended,
    input  wire logic            host_resume,
    input  wire logic            wake_status_clear,
    input  wire logic [4:0]      wake_source_clear,
    output logic                 wake_event_irq,
    output usrw_pkg::usrw_src_t  wake_source,
    output logic                 core_clock_enable,
    output logic                 resume_start
);
    localparam int CW = $clog2(RESUME_CYCLES + 1);

    logic                  low_power_enable;
    logic                  remote_wakeup_enable;
    logic                  wake_irq_enable;
    logic [4:0]            src_enable;
    logic [4:0]            pin_vec;
    logic [4:0]            raw_pulse;
    logic [4:0]            det;
    logic                  any_det;
    logic                  wake_arm;
    logic                  set_status;

    usrw_pkg::usrw_state_t state;
    usrw_pkg::usrw_state_t next_state;
    logic [CW-1:0]         cnt;
    logic [CW-1:0]         next_cnt;
    logic                  pending;
    logic                  next_pending;
    logic                  next_irq;
    logic [4:0]            next_src;
    logic                  next_resume;

    assign low_power_enable     = usb_control_reg[usrw_pkg::CTL_LOW_POWER_BIT];
    assign remote_wakeup_enable = usb_control_reg[usrw_pkg::CTL_REMOTE_WK_BIT];
    assign wake_irq_enable      = usb_irq_mask_reg[usrw_pkg::MSK_WAKE_IRQ_BIT];

    // vbus enable tied high: its detection cannot be turned off
    assign src_enable = {mcu_config_reg[usrw_pkg::CFG_CARD2_BIT],
                         mcu_config_reg[usrw_pkg::CFG_CARD1_BIT],
                         mcu_config_reg[usrw_pkg::CFG_PORT35_BIT],
                         mcu_config_reg[usrw_pkg::CFG_PORT34_BIT],
                         1'b1};
    assign pin_vec = {port33_pin, port32_pin, port35_pin, port34_pin, vbus_pin};

    genvar gi;
    generate
        for (gi = 0; gi < usrw_pkg::NUM_SOURCES; gi = gi + 1)
        begin : g_src
            usrw_change_det u_det
            (
                .clock        (clock),
                .rst          (rst),
                .pin          (pin_vec[gi]),
                .change_pulse (raw_pulse[gi])
            );
            assign det[gi] = raw_pulse[gi] & src_enable[gi];
        end
    endgenerate

    assign any_det  = |det;
    assign wake_arm = remote_wakeup_enable & wake_irq_enable;
    // clock available, enabled, not yet set; latched suspend events count too
    assign set_status = (state != usrw_pkg::USRW_STOP) && wake_irq_enable &&
                        !wake_event_irq && (any_det || pending);

    always_comb
    begin
        next_state  = state;
        next_cnt    = cnt;
        next_resume = 1'b0;
        case (state)
            usrw_pkg::USRW_RUN:
            begin
                if (suspended && remote_wakeup_enable && set_status)
                begin
                    next_state = usrw_pkg::USRW_ARMED;
                    next_cnt   = '0;
                end
                else if (suspended && low_power_enable)
                    next_state = usrw_pkg::USRW_STOP;
            end
            usrw_pkg::USRW_STOP:
            begin
                if (!suspended || host_resume)
                    next_state = usrw_pkg::USRW_RUN;
                else if (wake_arm && any_det)
                    next_state = usrw_pkg::USRW_WAKE;
            end
            usrw_pkg::USRW_WAKE:
            begin
                if (!suspended)
                    next_state = usrw_pkg::USRW_RUN;
                else if (set_status)
                begin
                    next_state = usrw_pkg::USRW_ARMED;
                    next_cnt   = '0;
                end
            end
            usrw_pkg::USRW_ARMED:
            begin
                if (!suspended)
                    next_state = usrw_pkg::USRW_RUN;
                else if (wake_status_clear ||
                         cnt == CW'(RESUME_CYCLES - 1))
                begin
                    next_state  = usrw_pkg::USRW_DONE;
                    next_resume = 1'b1;
                end
                else
                    next_cnt = cnt + CW'(1);
            end
            usrw_pkg::USRW_DONE:
            begin
                // clock stays up until the host ends suspend
                if (!suspended)
                    next_state = usrw_pkg::USRW_RUN;
            end
            default:
                next_state = usrw_pkg::USRW_RUN;
        endcase
    end

    always_comb
    begin
        // while the clock is off, events are held here instead of raising the irq
        if ((state == usrw_pkg::USRW_STOP) && any_det)
            next_pending = 1'b1;
        else if (set_status)
            next_pending = 1'b0;
        else
            next_pending = pending;

        // status is never set while already set; if a set and a clear coincide, the set wins
        if (set_status)
            next_irq = 1'b1;
        else if (wake_status_clear)
            next_irq = 1'b0;
        else
            next_irq = wake_event_irq;

        // a new event beats a write-one clear of the same bit
        next_src = (wake_source & ~wake_source_clear) | det;
    end

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            state             <= usrw_pkg::USRW_RUN;
            cnt               <= '0;
            pending           <= 1'b0;
            wake_event_irq    <= usrw_pkg::IRQ_RESET;
            wake_source       <= usrw_pkg::SRC_RESET;
            core_clock_enable <= 1'b1;
            resume_start      <= 1'b0;
        end
        else
        begin
            state             <= next_state;
            cnt               <= next_cnt;
            pending           <= next_pending;
            wake_event_irq    <= next_irq;
            wake_source       <= next_src;
            core_clock_enable <= (next_state != usrw_pkg::USRW_STOP);
            resume_start      <= next_resume;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    property p_irq_needs_enable;
        $rose(wake_event_irq) |-> $past(wake_irq_enable);
    endproperty
    a_irq_needs_enable: assert property (p_irq_needs_enable)
        else $error("wake irq rose without irq enable");

    property p_no_irq_while_stopped;
        $rose(wake_event_irq) |-> $past(core_clock_enable);
    endproperty
    a_no_irq_while_stopped: assert property (p_no_irq_while_stopped)
        else $error("wake irq rose while core clock stopped");

    property p_low_power_stop;
        (state == usrw_pkg::USRW_RUN && suspended && low_power_enable && !set_status)
            |=> !core_clock_enable ##1 (core_clock_enable || state == usrw_pkg::USRW_STOP);
    endproperty
    a_low_power_stop: assert property (p_low_power_stop)
        else $error("clock not stopped on low power suspend");

    property p_clock_runs_without_low_power;
        (state == usrw_pkg::USRW_RUN && !low_power_enable) |=> core_clock_enable;
    endproperty
    a_clock_runs_without_low_power: assert property (p_clock_runs_without_low_power)
        else $error("clock stopped with low power clear");

    property p_wake_restart;
        (state == usrw_pkg::USRW_STOP && suspended && wake_arm && any_det)
            |=> core_clock_enable ##1 wake_event_irq;
    endproperty
    a_wake_restart: assert property (p_wake_restart)
        else $error("remote wake event did not restart clock and raise irq");

    property p_resume_on_clear;
        (state == usrw_pkg::USRW_ARMED && suspended && wake_status_clear)
            |=> resume_start ##1 !resume_start;
    endproperty
    a_resume_on_clear: assert property (p_resume_on_clear)
        else $error("resume not started on irq clear");

    property p_resume_on_timeout;
        (state == usrw_pkg::USRW_ARMED && suspended && cnt == CW'(RESUME_CYCLES - 1))
            |=> resume_start;
    endproperty
    a_resume_on_timeout: assert property (p_resume_on_timeout)
        else $error("resume not started at timeout");

    property p_resume_needs_remote_wake;
        $rose(state == usrw_pkg::USRW_ARMED) |-> $past(remote_wakeup_enable);
    endproperty
    a_resume_needs_remote_wake: assert property (p_resume_needs_remote_wake)
        else $error("resume armed without remote wakeup enable");

    property p_vbus_sets_status;
        (det[0] && state != usrw_pkg::USRW_STOP && wake_irq_enable && !wake_event_irq)
            |=> wake_event_irq && wake_source.vbus;
    endproperty
    a_vbus_sets_status: assert property (p_vbus_sets_status)
        else $error("vbus change did not set status");

    property p_gpio_gated;
        $rose(wake_source.port34) |-> $past(mcu_config_reg[usrw_pkg::CFG_PORT34_BIT]);
    endproperty
    a_gpio_gated: assert property (p_gpio_gated)
        else $error("port 3.4 event with detection disabled");

    property p_pending_raises;
        (pending && state != usrw_pkg::USRW_STOP && wake_irq_enable && !wake_event_irq)
            |=> wake_event_irq && !pending;
    endproperty
    a_pending_raises: assert property (p_pending_raises)
        else $error("latched event did not raise irq");

    property p_clear_keeps_sources;
        (wake_status_clear && wake_event_irq && wake_source_clear == 5'h00)
            |=> !wake_event_irq && ((wake_source & $past(wake_source)) == $past(wake_source));
    endproperty
    a_clear_keeps_sources: assert property (p_clear_keeps_sources)
        else $error("status clear lost source bits or kept irq");

    property p_event_raises_irq;
        (any_det && state != usrw_pkg::USRW_STOP && wake_irq_enable && !wake_event_irq)
            |=> wake_event_irq;
    endproperty
    a_event_raises_irq: assert property (p_event_raises_irq)
        else $error("enabled event with clock running did not raise irq");

    property p_source_held;
        (wake_source.vbus && !wake_source_clear[0]) |=> wake_source.vbus;
    endproperty
    a_source_held: assert property (p_source_held)
        else $error("vbus source bit dropped without its clear");

    c_resume_by_clear: cover property (state == usrw_pkg::USRW_ARMED && wake_status_clear
                                       ##1 resume_start);
    c_resume_by_timeout: cover property (cnt == CW'(RESUME_CYCLES - 1) ##1 resume_start);
    c_stop_then_wake: cover property (state == usrw_pkg::USRW_STOP ##1
                                      state == usrw_pkg::USRW_WAKE);
    c_pending_raise: cover property (pending ##1 $rose(wake_event_irq));
endmodule

// *** usrw_wake_ctrl_tb_top.sv ***
/*
 * usrw_wake_ctrl_tb_top: directed bench for the wake logic.
 * Assumes a shortened resume timeout and firmware register images on ports.
 */
`timescale 1ns/1ns
module usrw_wake_ctrl_tb_top;
    localparam int RC = 20;
    logic                clock = 1'b0;
    logic                rst = 1'b1;
    logic [7:0]          ctl = 8'h00;
    logic [7:0]          msk = 8'h00;
    logic [7:0]          cfg = 8'h00;
    logic [4:0]          pins = 5'h00;
    logic                go_suspend = 1'b0;
    logic                wake_host = 1'b0;
    logic                st_clr = 1'b0;
    logic [4:0]          src_clr = 5'h00;
    logic                irq;
    usrw_pkg::usrw_src_t src;
    logic                clk_en;
    logic                resume_start;
    logic                suspended;
    logic                host_resume;
    int                  resumes;
    int                  fail_count = 0;
    int                  n_tests = 0;
    int                  n;

    always #25 clock = ~clock;

    usrw_wake_ctrl #(.RESUME_CYCLES(RC)) i_usrw_wake_ctrl (
        .clock(clock), .rst(rst), .usb_control_reg(ctl), .usb_irq_mask_reg(msk),
        .mcu_config_reg(cfg), .vbus_pin(pins[0]), .port34_pin(pins[1]),
        .port35_pin(pins[2]), .port32_pin(pins[3]), .port33_pin(pins[4]),
        .suspended(suspended), .host_resume(host_resume), .wake_status_clear(st_clr),
        .wake_source_clear(src_clr), .wake_event_irq(irq), .wake_source(src),
        .core_clock_enable(clk_en), .resume_start(resume_start));

    usrw_host_model i_usrw_host_model (
        .clock(clock), .rst(rst), .go_suspend(go_suspend), .wake_host(wake_host),
        .resume_start(resume_start), .suspended(suspended), .host_resume(host_resume),
        .resume_count(resumes));

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic cyc(input int k);
        repeat (k) @(negedge clock);
    endtask

    task automatic do_reset(input logic [7:0] c, input logic [7:0] m, input logic [7:0] f);
        @(negedge clock);
        rst = 1'b1;
        go_suspend = 1'b0;
        ctl = c;
        msk = m;
        cfg = f;
        cyc(20);
        rst = 1'b0;
        cyc(6);
    endtask

    // waits on irq, resume_start or clock enable; n counts cycles taken
    task automatic wait_for(input int sel, output int k);
        k = 0;
        while (k < 60 && !((sel == 0 && irq === 1'b1) || (sel == 1 && resume_start === 1'b1)
               || (sel == 2 && clk_en === 1'b1)))
        begin
            @(negedge clock);
            k++;
        end
    endtask

    task automatic flip(input int idx);
        pins[idx] = ~pins[idx];
    endtask

    task automatic pulse_clr(input logic st, input logic [4:0] s);
        st_clr = st;
        src_clr = s;
        cyc(1);
        st_clr = 1'b0;
        src_clr = 5'h00;
        cyc(1);
    endtask

    task automatic close_out;
        $display("comparisons %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    initial
    begin
        // suspended with clock running, only port34 of the gpio sources enabled
        do_reset(8'h00, 8'h04, 8'h04);
        go_suspend = 1'b1;
        check({5'h00, irq, clk_en, resume_start}, 8'h02);
        check({3'h0, src}, 8'h00);
        flip(0);
        wait_for(0, n);
        check({3'h0, src}, 8'h01);
        check({6'h0, irq, clk_en}, 8'h03);
        flip(2);
        flip(1);
        cyc(10);
        check({3'h0, src}, 8'h03);
        check({7'h0, irq}, 8'h01);
        pulse_clr(1'b1, 5'h00);
        check({2'h0, src, irq}, 8'h06);
        pulse_clr(1'b0, 5'h03);
        check({3'h0, src}, 8'h00);
        msk = 8'h00;
        flip(0);
        cyc(10);
        check({2'h0, src, irq}, 8'h02);
        $display("test normal run done");

        // low power and remote wake, resume by timeout
        do_reset(8'h60, 8'h04, 8'h10);
        go_suspend = 1'b1;
        cyc(4);
        check({7'h0, clk_en}, 8'h00);
        flip(3);
        wait_for(2, n);
        check({7'h0, clk_en}, 8'h01);
        wait_for(0, n);
        wait_for(1, n);
        check(n[7:0], RC[7:0]);
        check({3'h0, src}, 8'h08);
        cyc(2);
        check(resumes[7:0], 8'h01);
        $display("test remote wake timeout done");

        // clock running, remote wake, resume on clear
        do_reset(8'h20, 8'h04, 8'h00);
        go_suspend = 1'b1;
        cyc(3);
        flip(0);
        wait_for(0, n);
        check({7'h0, clk_en}, 8'h01);
        cyc(2);
        st_clr = 1'b1;
        cyc(1);
        // resume_start stands one cycle only: look right after the clear edge
        check({6'h0, resume_start, irq}, 8'h02);
        st_clr = 1'b0;
        cyc(2);
        check(resumes[7:0], 8'h01);
        $display("test resume on clear done");

        // low power without remote wake: latch, then irq after host resume
        do_reset(8'h40, 8'h04, 8'h20);
        go_suspend = 1'b1;
        cyc(4);
        flip(4);
        cyc(12);
        check({3'h0, src}, 8'h10);
        check({6'h0, irq, clk_en}, 8'h00);
        go_suspend = 1'b0;
        wake_host = 1'b1;
        cyc(1);
        wake_host = 1'b0;
        wait_for(0, n);
        check({6'h0, irq, clk_en}, 8'h03);
        cyc(RC + 4);
        check(resumes[7:0], 8'h00);
        $display("test low power latch done");
        close_out();
    end

    initial
    begin
        #(3000 * 50);
        fail_count++;
        close_out();
    end
endmodule
